// *** dv/dcb_host.sv ***
// Host processor model driving the micro bus of the error status block
`timescale 1ns/100ps
module dcb_host
   import dcb_pkg::*;
#(
   parameter logic [3:0] ADDR = 4'h9   // Controller address used by every command
)
(
   // Clock and controller status
   input  wire logic        mclk,
   input  wire logic        xfer_busy,
   input  wire logic [7:0]  data_out,
   input  wire logic        data_oe,
   // Bus lines driven by the host
   output logic      [7:0]  cmd_byte,
   output logic             strobe_in,
   output logic             strobe_out,
   output logic      [7:0]  data_in
);
   initial begin
      cmd_byte   = 8'h00;
      strobe_in  = 1'b0;
      strobe_out = 1'b0;
      data_in    = 8'h00;
   end
   // Output command: framed like an input one, data byte on the data lines
   task automatic out_cmd(input logic [3:0] code, input logic [7:0] d);
      while (xfer_busy === 1'b1 && code < 4'h2) @(posedge mclk);
      @(posedge mclk);
      cmd_byte   <= {code, ADDR};
      data_in    <= d;
      strobe_out <= 1'b1;
      @(posedge mclk);
      strobe_out <= 1'b0;
      data_in    <= ~d;   // Released lines do not keep the last value
   endtask
   // Input command: sample once the registered answer has settled
   task automatic in_cmd(input logic [3:0] code, output logic [8:0] v);
      while (xfer_busy === 1'b1 && code == IN_RDBUF) @(posedge mclk);
      @(posedge mclk);
      cmd_byte  <= {code, ADDR};
      strobe_in <= 1'b1;
      repeat (3) @(posedge mclk);
      #1 v = {data_oe, data_out};
      @(posedge mclk);
      strobe_in <= 1'b0;
   endtask
endmodule // dcb_host

// *** dv/tb.sv ***
// Self-checking bench of the error status and sector buffer block
`timescale 1ns/100ps
module tb
   import dcb_pkg::*;
;
   logic mclk, rst_n, wbuf_ready, data_oe, xfer_busy, seek_busy, strobe_in, strobe_out;
   logic prot_switch, prot_tag, drive_ready, op_valid, sector_mark, data_phase;
   logic sect_not_found, sec_par_err, seek_fault, bad_seek_addr, power_loss;
   logic fault_line_ok, wr_enable, wr_current, wr_clock, rd_enable;
   logic [7:0] cmd_byte, data_in, data_out, err_status;
   logic [3:0] ctrl_addr;
   logic [5:0] pv;        // Pulsed inputs
   logic [8:0] v;         // Output enable and byte seen
   int num_errors, checked, cyc;
   dcb_err_buf #(.TMO_CYCLES(50), .SYS_ID(8'hA6)) uut (
      .mclk(mclk), .rst_n(rst_n), .cmd_byte(cmd_byte), .strobe_in(strobe_in),
      .strobe_out(strobe_out), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
      .wbuf_ready(wbuf_ready), .ctrl_addr(ctrl_addr), .prot_switch(prot_switch),
      .prot_tag(prot_tag), .drive_ready(drive_ready), .op_valid(op_valid),
      .sector_mark(sector_mark), .sector_pulse(pv[2]), .data_phase(data_phase),
      .crc_err(pv[3]), .xfer_done(pv[0]), .sect_not_found(sect_not_found),
      .seek_done(pv[1]), .servo_par_err(pv[5]), .sec_par_err(sec_par_err),
      .seek_fault(seek_fault), .bad_seek_addr(bad_seek_addr), .power_loss(power_loss),
      .fault_line_ok(fault_line_ok), .malfunction(pv[4]), .wr_enable(wr_enable),
      .wr_current(wr_current), .wr_clock(wr_clock), .rd_enable(rd_enable),
      .err_status(err_status), .xfer_busy(xfer_busy), .seek_busy(seek_busy));
   dcb_host #(.ADDR(4'h9)) host (.mclk(mclk), .xfer_busy(xfer_busy), .data_out(data_out),
      .data_oe(data_oe), .cmd_byte(cmd_byte), .strobe_in(strobe_in),
      .strobe_out(strobe_out), .data_in(data_in));
   // Clock
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   task automatic pulse(input int i);
      @(posedge mclk) pv[i] <= 1'b1;
      @(posedge mclk) pv[i] <= 1'b0;
   endtask
   // One comparison, counted
   task automatic cmp(input string n, input logic [8:0] e, s);
      checked++;
      if (s !== e) begin
         $display("[FAIL] %s expected %h seen %h", n, e, s);
         num_errors++;
      end
   endtask
   // Read a byte over the bus and compare the masked value
   task automatic chk(input string n, input logic [3:0] c, input logic [8:0] e, m = 9'h1FF);
      host.in_cmd(c, v);
      cmp(n, e, v & m);
   endtask
   task automatic restore();  // Restore also starts a seek, so end it
      host.out_cmd(OUT_RESTORE, 8'h00);
      pulse(1);
   endtask
   task automatic test_done();
      $display("Checks made %0d, mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Hang guard, far above the length of the sequence
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         test_done();
      end
   end
   // Main sequence
   initial begin
      {prot_switch, prot_tag, sector_mark, data_phase, sect_not_found, sec_par_err} = 6'h00;
      {seek_fault, bad_seek_addr, power_loss, wr_enable, wr_current, wr_clock} = 6'h00;
      {rd_enable, pv, num_errors, checked, cyc} = '0;
      {drive_ready, op_valid, fault_line_ok, ctrl_addr, rst_n} = {3'b111, 4'h9, 1'b0};
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      chk("status2 reset", IN_STAT2, 9'h100);
      chk("system id", IN_SYSID, 9'h1A6);
      host.out_cmd(OUT_SETPTR, 8'hFF);
      host.out_cmd(OUT_WRBUF, 8'h11);
      @(negedge mclk) cmp("wbuf ready", 9'h001, {8'h00, wbuf_ready});
      host.out_cmd(OUT_WRBUF, 8'h22);
      host.out_cmd(OUT_SETPTR, 8'hFF);
      chk("buffer FF", IN_RDBUF, 9'h111);
      chk("buffer 00", IN_RDBUF, 9'h122);
      prot_switch <= 1'b1;
      host.out_cmd(OUT_WRSEC, 8'h01);
      chk("protect err", IN_STAT2, 9'h101, 9'h1EF);
      repeat (60) @(posedge mclk);
      chk("xfer timeout", IN_STAT2, 9'h103, 9'h1EF);
      prot_switch <= 1'b0;
      host.out_cmd(OUT_WRSEC, 8'h01);
      chk("protect clear", IN_STAT2, 9'h102, 9'h1EF);
      pulse(0);
      chk("pointer zeroed", IN_RDBUF, 9'h122);
      host.out_cmd(OUT_RESET, 8'h00);
      chk("reset clears", IN_STAT2, 9'h100, 9'h1EF);
      restore();
      host.out_cmd(OUT_SEEK, 8'h05);
      @(negedge mclk) cmp("seek busy", 9'h002, {7'h00, seek_busy, xfer_busy});
      repeat (60) @(posedge mclk);
      chk("seek timeout", IN_STAT2, 9'h140);
      restore();
      chk("restore clears", IN_STAT2, 9'h100);
      data_phase <= 1'b1;
      host.out_cmd(OUT_RDSEC, 8'h02);
      pulse(3);
      chk("crc err", IN_STAT2, 9'h108);
      @(negedge mclk) cmp("busy after crc", 9'h000, {7'h00, seek_busy, xfer_busy});
      host.out_cmd(OUT_RDSEC, 8'h02);
      pulse(2);
      chk("overrun", IN_STAT2, 9'h104);
      host.out_cmd(OUT_RDSEC, 8'h02);
      chk("overrun clear", IN_STAT2, 9'h100);
      pulse(0);
      data_phase <= 1'b0;
      pulse(4);
      pulse(5);
      host.out_cmd(OUT_RESET, 8'h00);
      chk("fault sticky", IN_STAT2, 9'h130);
      @(negedge mclk) cmp("err_status", 9'h030, {1'b0, err_status});
      restore();
      chk("fault clear", IN_STAT2, 9'h100);
      wr_current <= 1'b1;
      @(posedge mclk) wr_current <= 1'b0;
      chk("write fault", IN_STAT2, 9'h110);
      restore();
      drive_ready <= 1'b0;
      host.out_cmd(OUT_RDSEC, 8'h03);
      chk("not ready read", IN_STAT2, 9'h110);
      test_done();
   end
endmodule // tb

// *** logic/dcb_err_buf.sv ***
// Error status byte two, system id and sector buffer access on the micro bus
`timescale 1ns/100ps
module dcb_err_buf
   import dcb_pkg::*;
#(
   parameter int          TMO_CYCLES = TMO_CYC,   // 200 ms in clocks, shorten in simulation
   parameter logic [7:0]  SYS_ID     = 8'h5A      // Identification code, value arbitrary
)
(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // Micro bus
   input  wire logic [7:0]  cmd_byte,
   input  wire logic        strobe_in,
   input  wire logic        strobe_out,
   input  wire logic [7:0]  data_in,
   output logic      [7:0]  data_out,
   output logic             data_oe,
   output logic             wbuf_ready,
   input  wire logic [3:0]  ctrl_addr,
   // Drive and sequencer status
   input  wire logic        prot_switch,
   input  wire logic        prot_tag,
   input  wire logic        drive_ready,
   input  wire logic        op_valid,
   input  wire logic        sector_mark,
   input  wire logic        sector_pulse,
   input  wire logic        data_phase,
   input  wire logic        crc_err,
   input  wire logic        xfer_done,
   input  wire logic        sect_not_found,
   input  wire logic        seek_done,
   input  wire logic        servo_par_err,
   input  wire logic        sec_par_err,
   // Drive fault sources
   input  wire logic        seek_fault,
   input  wire logic        bad_seek_addr,
   input  wire logic        power_loss,
   input  wire logic        fault_line_ok,
   input  wire logic        malfunction,
   input  wire logic        wr_enable,
   input  wire logic        wr_current,
   input  wire logic        wr_clock,
   input  wire logic        rd_enable,
   // Block status
   output logic      [7:0]  err_status,
   output logic             xfer_busy,
   output logic             seek_busy
);
   typedef struct packed {
      logic [7:0]       st2;        // Error status byte two
      logic [PTR_W-1:0] ptr;        // Buffer address pointer
      logic             xbusy;      // Sector transfer running
      logic             xwrite;     // Transfer writes the disk
      logic             xverify;    // Transfer includes a read-back
      logic             sbusy;      // Seek or restore running
      logic [TMO_W-1:0] xtmr;       // Transfer age
      logic [TMO_W-1:0] stmr;       // Seek age
      logic             sin_d;      // Strobe delays for edge detection
      logic             sout_d;
      logic             rd_act;     // Buffer read strobe in progress
      logic [7:0]       dout;       // Byte on the data lines
      logic             oe;         // Data lines driven
      logic [6:0]       wtmr;       // Cycles since last write-clock edge
      logic             wclk_d;
   } dcb_main_st_t;

   localparam logic [TMO_W-1:0] TMO_LAST = TMO_W'(TMO_CYCLES - 1);

   dcb_main_st_t          st_ff;
   dcb_main_st_t          nxt_st;
   logic [3:0]            sub;          // Sub-command nibble
   logic                  hit;          // Our address on the bus
   logic                  out_go;       // Rising output strobe for us
   logic                  in_rise;
   logic                  in_fall;
   logic                  prot;
   logic                  c_rd, c_wr, c_wv, c_rst, c_rso, c_seek, c_ptr, c_wbuf, c_disk;
   logic                  x_end;
   logic                  wr_fault;
   logic                  illegal;
   logic [7:0]            set_v;
   logic [7:0]            clr_v;
   logic                  rd_hold;
   logic                  f_valid;
   logic [16:0]           f_data;
   logic                  ram_we;
   logic [PTR_W-1:0]      ram_addr;
   logic [WORD_W-1:0]     ram_rd;
   logic [7:0]            st1;

   // Decode one output command on the rising edge of strobe two
   function automatic logic is_cmd(input logic go, input logic [3:0] s, input logic [3:0] c);
      return go && (s == c);
   endfunction

   assign sub     = cmd_byte[SUB_MSB:SUB_LSB];
   assign hit     = (cmd_byte[ADR_MSB:ADR_LSB] == ctrl_addr);
   assign out_go  = strobe_out && !st_ff.sout_d && hit;
   assign in_rise = strobe_in && !st_ff.sin_d && hit;
   assign in_fall = !strobe_in && st_ff.sin_d;
   assign prot    = prot_switch || prot_tag;
   assign c_rd    = is_cmd(out_go, sub, OUT_RDSEC);
   assign c_wr    = is_cmd(out_go, sub, OUT_WRSEC);
   assign c_wv    = is_cmd(out_go, sub, OUT_WVSEC);
   assign c_rst   = is_cmd(out_go, sub, OUT_RESET);
   assign c_rso   = is_cmd(out_go, sub, OUT_RESTORE);
   assign c_seek  = is_cmd(out_go, sub, OUT_SEEK);
   assign c_ptr   = is_cmd(out_go, sub, OUT_SETPTR);
   assign c_wbuf  = is_cmd(out_go, sub, OUT_WRBUF);
   assign c_disk  = c_rd || c_wr || c_wv || c_seek || is_cmd(out_go, sub, OUT_TRKMSB);
   // A transfer ends on completion, sector not found, overrun, CRC error or transfer timeout
   assign x_end   = st_ff.xbusy && (xfer_done || sect_not_found || set_v[E_OVRN]
                                    || set_v[E_CRC] || set_v[E_XTMO]);

   // Write fault: current and enable disagree, or the write clock went silent
   assign wr_fault = (wr_enable && !wr_current) || (wr_current && !wr_enable)
                     || (wr_enable && (st_ff.wtmr == WCLK_LIMIT));

   // Illegal procedure seen by the controller
   assign illegal = (c_disk && (!op_valid || sector_mark))
                    || ((c_rd || c_wr || c_wv) && !drive_ready)
                    || ((c_wr || c_wv) && prot)
                    || (rd_enable && wr_enable);

   // Set and clear terms of each error flag; a set always beats a clear
   always_comb begin
      set_v = 8'h00;
      clr_v = 8'h00;
      set_v[E_WPROT] = (c_wr || c_wv) && prot;
      clr_v[E_WPROT] = c_rst || c_rso || ((c_wr || c_wv) && !prot);
      set_v[E_XTMO]  = st_ff.xbusy && (st_ff.xtmr == TMO_LAST);
      clr_v[E_XTMO]  = c_rst || c_rso;
      set_v[E_OVRN]  = st_ff.xbusy && data_phase && sector_pulse;
      clr_v[E_OVRN]  = c_rd || c_wr || c_wv || c_rst || c_rso;
      set_v[E_CRC]   = st_ff.xbusy && (!st_ff.xwrite || st_ff.xverify) && crc_err;
      clr_v[E_CRC]   = c_rd || c_wr || c_wv || c_rst || c_rso;
      set_v[E_FAULT] = seek_fault || bad_seek_addr || wr_fault || illegal
                       || power_loss || !fault_line_ok || malfunction;
      clr_v[E_FAULT] = c_rso;
      set_v[E_APAR]  = drive_ready && servo_par_err;
      clr_v[E_APAR]  = c_rso;
      set_v[E_STMO]  = st_ff.sbusy && (st_ff.stmr == TMO_LAST);
      clr_v[E_STMO]  = c_rso;
      set_v[E_BPAR]  = (in_fall && st_ff.rd_act && (^ram_rd))
                       || (st_ff.xbusy && st_ff.xwrite && sec_par_err);
      clr_v[E_BPAR]  = c_rso;
   end

   // Status byte one, a summary view for the processor
   assign st1 = {2'b00, prot,
                 |{st_ff.st2[E_BPAR], st_ff.st2[E_FAULT:E_WPROT]},
                 |st_ff.st2[E_STMO:E_FAULT], st_ff.sbusy, st_ff.xbusy, drive_ready};

   // Buffer reads keep the memory port; queued writes wait behind them
   assign rd_hold  = st_ff.rd_act || (strobe_in && hit && (sub == IN_RDBUF));
   assign ram_we   = f_valid && !rd_hold;
   assign ram_addr = ram_we ? f_data[16:9] : st_ff.ptr;

   // Next state of the whole block
   always_comb begin
      nxt_st        = st_ff;
      nxt_st.sin_d  = strobe_in;
      nxt_st.sout_d = strobe_out;
      nxt_st.wclk_d = wr_clock;
      nxt_st.st2    = (st_ff.st2 & ~clr_v) | set_v;
      // Transfer tracking, restarted by each sector command
      if (c_rd || c_wr || c_wv) begin
         nxt_st.xbusy   = 1'b1;
         nxt_st.xwrite  = c_wr || c_wv;
         nxt_st.xverify = c_wv;
         nxt_st.xtmr    = '0;
      end else if (x_end) begin
         nxt_st.xbusy = 1'b0;
      end else if (st_ff.xbusy) begin
         nxt_st.xtmr = st_ff.xtmr + TMO_W'(1);
      end
      // Seek tracking, restore counts as a seek
      if (c_seek || c_rso) begin
         nxt_st.sbusy = 1'b1;
         nxt_st.stmr  = '0;
      end else if (st_ff.sbusy && (seek_done || set_v[E_STMO])) begin
         nxt_st.sbusy = 1'b0;
      end else if (st_ff.sbusy) begin
         nxt_st.stmr = st_ff.stmr + TMO_W'(1);
      end
      // Write-clock watchdog, saturates at its limit
      if (!wr_enable || (wr_clock != st_ff.wclk_d)) begin
         nxt_st.wtmr = '0;
      end else if (st_ff.wtmr != WCLK_LIMIT) begin
         nxt_st.wtmr = st_ff.wtmr + 7'h01;
      end
      // Buffer read strobe window
      if (in_rise) begin
         nxt_st.rd_act = (sub == IN_RDBUF);
      end else if (in_fall) begin
         nxt_st.rd_act = 1'b0;
      end
      // Pointer: finished transfer wins, then load, then advance (wraps)
      if (st_ff.xbusy && xfer_done) begin
         nxt_st.ptr = PTR_RST;
      end else if (c_ptr) begin
         nxt_st.ptr = data_in;
      end else if (c_wbuf && wbuf_ready) begin
         nxt_st.ptr = st_ff.ptr + 8'h01;
      end else if (in_fall && st_ff.rd_act) begin
         nxt_st.ptr = st_ff.ptr + 8'h01;
      end
      // Data lines: selected byte, driven only under an addressed input strobe
      nxt_st.oe = strobe_in && hit && (sub <= IN_RDBUF);
      unique case (sub)
         IN_STAT1: nxt_st.dout = st1;
         IN_STAT2: nxt_st.dout = st_ff.st2;
         IN_SYSID: nxt_st.dout = SYS_ID;
         IN_RDBUF: nxt_st.dout = ram_rd[7:0];
         default:  nxt_st.dout = 8'h00;
      endcase
   end

   // State register
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff     <= '0;
         st_ff.st2 <= ST2_RST;
         st_ff.ptr <= PTR_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Written bytes queue with their address and parity
   dcb_pair_fifo #(.W(17)) u_wq (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .in_valid  (c_wbuf),
      .in_ready  (wbuf_ready),
      .in_data   ({st_ff.ptr, ^data_in, data_in}),
      .out_valid (f_valid),
      .out_ready (!rd_hold),
      .out_data  (f_data)
   );

   // Sector buffer
   dcb_sector_ram u_ram (
      .mclk  (mclk),
      .we    (ram_we),
      .addr  (ram_addr),
      .wdata (f_data[8:0]),
      .rdata (ram_rd)
   );

   assign data_out   = st_ff.dout;
   assign data_oe    = st_ff.oe;
   assign err_status = st_ff.st2;
   assign xfer_busy  = st_ff.xbusy;
   assign seek_busy  = st_ff.sbusy;

   // Checks beside the logic
   a_wp_set: assert property (@(posedge mclk) disable iff (!rst_n)
      (c_wr || c_wv) && prot |=> err_status[E_WPROT]) else $error("wp flag not set");
   a_wp_clear: assert property (@(posedge mclk) disable iff (!rst_n)
      $fell(err_status[E_WPROT]) |-> $past(c_rst || c_rso || c_wr || c_wv))
      else $error("wp flag cleared without cause");
   a_xtmo_set: assert property (@(posedge mclk) disable iff (!rst_n)
      xfer_busy && (st_ff.xtmr == TMO_LAST) |=> err_status[E_XTMO])
      else $error("transfer timer broken");
   a_xtmo_hold: assert property (@(posedge mclk) disable iff (!rst_n)
      $fell(err_status[E_XTMO]) |-> $past(c_rst || c_rso)) else $error("timeout lost");
   a_ovrn_set: assert property (@(posedge mclk) disable iff (!rst_n)
      xfer_busy && data_phase && sector_pulse
      |=> err_status[E_OVRN] && (!xfer_busy || $past(c_rd || c_wr || c_wv)))
      else $error("overrun missed");
   a_ovrn_clear: assert property (@(posedge mclk) disable iff (!rst_n)
      c_rd && !(xfer_busy && data_phase && sector_pulse) |=> !err_status[E_OVRN])
      else $error("overrun not cleared");
   a_crc_hold: assert property (@(posedge mclk) disable iff (!rst_n)
      $fell(err_status[E_CRC]) |-> $past(c_rd || c_wr || c_wv || c_rst || c_rso))
      else $error("crc flag lost");
   a_fault_set: assert property (@(posedge mclk) disable iff (!rst_n)
      wr_current && !wr_enable |=> err_status[E_FAULT]) else $error("write fault missed");
   a_fault_hold: assert property (@(posedge mclk) disable iff (!rst_n)
      $fell(err_status[E_FAULT]) |-> $past(c_rso)) else $error("fault cleared early");
   a_illegal_rw: assert property (@(posedge mclk) disable iff (!rst_n)
      c_rd && !drive_ready |=> err_status[E_FAULT]) else $error("illegal read missed");
   a_apar_hold: assert property (@(posedge mclk) disable iff (!rst_n)
      drive_ready && servo_par_err
      |=> err_status[E_APAR] ##1 (err_status[E_APAR] || $past(c_rso)))
      else $error("parity flag not held");
   a_stmo_set: assert property (@(posedge mclk) disable iff (!rst_n)
      seek_busy && (st_ff.stmr == TMO_LAST)
      |=> err_status[E_STMO] && (!seek_busy || $past(c_seek || c_rso)))
      else $error("seek timeout missed");
   a_bpar_hold: assert property (@(posedge mclk) disable iff (!rst_n)
      $fell(err_status[E_BPAR]) |-> $past(c_rso)) else $error("buffer parity lost");
   a_id_drive: assert property (@(posedge mclk) disable iff (!rst_n)
      (strobe_in && hit && (sub == IN_SYSID)) [*2] |-> data_oe && (data_out == SYS_ID))
      else $error("id not driven");
   a_ptr_load: assert property (@(posedge mclk) disable iff (!rst_n)
      c_ptr && !(xfer_busy && xfer_done) |=> st_ff.ptr == $past(data_in))
      else $error("pointer not loaded");
   a_ptr_zero: assert property (@(posedge mclk) disable iff (!rst_n)
      xfer_busy && xfer_done |=> st_ff.ptr == PTR_RST) else $error("pointer not zeroed");
   a_wbuf_step: assert property (@(posedge mclk) disable iff (!rst_n)
      c_wbuf && wbuf_ready && !c_ptr && !(xfer_busy && xfer_done)
      |=> st_ff.ptr == $past(st_ff.ptr) + 8'h01) else $error("pointer not advanced");
   a_rbuf_step: assert property (@(posedge mclk) disable iff (!rst_n)
      in_fall && st_ff.rd_act && !c_ptr && !c_wbuf && !(xfer_busy && xfer_done)
      |=> st_ff.ptr == $past(st_ff.ptr) + 8'h01) else $error("read did not advance");
endmodule // dcb_err_buf

// *** logic/dcb_pair_fifo.sv ***
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
module dcb_pair_fifo
   import dcb_pkg::*;
#(
   parameter int W = 17
)
(
   // Clock and reset
   input  wire logic          mclk,
   input  wire logic          rst_n,
   // Filling side
   input  wire logic          in_valid,
   output logic               in_ready,
   input  wire logic [W-1:0]  in_data,
   // Draining side
   output logic               out_valid,
   input  wire logic          out_ready,
   output logic      [W-1:0]  out_data
);
   typedef struct packed {
      logic [W-1:0] slot0;   // Head entry
      logic [W-1:0] slot1;   // Second entry
      logic [1:0]   cnt;     // Entries held
   } dcb_fifo_st_t;

   dcb_fifo_st_t st_ff;
   dcb_fifo_st_t nxt_st;
   logic         push;
   logic         pop;

   assign in_ready  = (st_ff.cnt != 2'h2);
   assign out_valid = (st_ff.cnt != 2'h0);
   assign out_data  = st_ff.slot0;
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Shift on pop, fill the first free slot on push
   always_comb begin
      nxt_st = st_ff;
      if (pop) begin
         nxt_st.slot0 = st_ff.slot1;
      end
      if (push) begin
         if ((st_ff.cnt == 2'h0) || ((st_ff.cnt == 2'h1) && pop)) begin
            nxt_st.slot0 = in_data;
         end else begin
            nxt_st.slot1 = in_data;
         end
      end
      nxt_st.cnt = st_ff.cnt + {1'b0, push} - {1'b0, pop};
   end

   // State register
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
endmodule // dcb_pair_fifo

// *** logic/dcb_pkg.sv ***
// Shared constants of the disk-controller error status and buffer block
package dcb_pkg;
   // Micro bus command byte layout
   localparam int          SUB_MSB       = 7;            // Sub-command in the upper half
   localparam int          SUB_LSB       = 4;
   localparam int          ADR_MSB       = 3;            // Controller address in the lower half
   localparam int          ADR_LSB       = 0;
   // Input command codes (strobe 1)
   localparam logic [3:0]  IN_STAT1      = 4'h0;
   localparam logic [3:0]  IN_STAT2      = 4'h1;
   localparam logic [3:0]  IN_SYSID      = 4'h2;
   localparam logic [3:0]  IN_RDBUF      = 4'h3;
   // Output command codes (strobe 2)
   localparam logic [3:0]  OUT_SETPTR    = 4'h0;
   localparam logic [3:0]  OUT_WRBUF     = 4'h1;
   localparam logic [3:0]  OUT_TRKMSB    = 4'h2;
   localparam logic [3:0]  OUT_SEEK      = 4'h3;
   localparam logic [3:0]  OUT_RDSEC     = 4'h4;
   localparam logic [3:0]  OUT_WRSEC     = 4'h5;
   localparam logic [3:0]  OUT_WVSEC     = 4'h6;
   localparam logic [3:0]  OUT_RESTORE   = 4'h7;
   localparam logic [3:0]  OUT_RESET     = 4'h8;
   // Error status byte two, bit positions
   localparam int          E_WPROT       = 0;
   localparam int          E_XTMO        = 1;
   localparam int          E_OVRN        = 2;
   localparam int          E_CRC         = 3;
   localparam int          E_FAULT       = 4;
   localparam int          E_APAR        = 5;
   localparam int          E_STMO        = 6;
   localparam int          E_BPAR        = 7;
   localparam logic [7:0]  ST2_RST       = 8'h00;        // All flags clear after reset
   // Sector buffer
   localparam int          PTR_W         = 8;            // 256 byte locations
   localparam int          BUF_DEPTH     = 256;
   localparam int          WORD_W        = 9;            // Data byte plus parity bit
   localparam logic [7:0]  PTR_RST       = 8'h00;
   // Timeouts
   localparam int          TMO_MS        = 200;          // Transfer and seek limit, ms
   localparam int          MCLK_KHZ      = 125000;       // 125 MHz system clock
   localparam int          TMO_CYC       = TMO_MS * MCLK_KHZ;
   localparam int          TMO_W         = 25;
   localparam logic [6:0]  WCLK_LIMIT    = 7'h40;        // Write-clock silence, cycles
endpackage

// *** logic/dcb_sector_ram.sv ***
// Sector buffer memory, 256 words of data plus parity, registered read
`timescale 1ns/100ps
module dcb_sector_ram
   import dcb_pkg::*;
(
   // Clock
   input  wire logic                mclk,
   // Single access port
   input  wire logic                we,
   input  wire logic [PTR_W-1:0]    addr,
   input  wire logic [WORD_W-1:0]   wdata,
   output logic      [WORD_W-1:0]   rdata
);
   logic [WORD_W-1:0] mem [BUF_DEPTH];   // Storage, no reset by design

   // Write when asked, otherwise read the addressed word into the output flop
   always_ff @(posedge mclk) begin
      if (we) begin
         mem[addr] <= wdata;
      end else begin
         rdata <= mem[addr];
      end
   end
endmodule // dcb_sector_ram
